// [rtl/cef_pkg.sv]
package cef_pkg;
   // Register offsets
   localparam logic [3:0] CEF_NOTIFY_OFF = 4'h0;  // Notification flags
   localparam logic [3:0] CEF_ERROR_OFF = 4'hB;   // error_flags_one
   localparam logic [3:0] CEF_MASK_OFF = 4'h1;    // Error interrupt enables
   localparam logic [3:0] CEF_NMASK_OFF = 4'h2;   // Notification interrupt enables
   localparam logic [3:0] CEF_CTRL_OFF = 4'h3;    // Control bits
   localparam logic [3:0] CEF_STAT_OFF = 4'h4;    // Live status
   // Notification field positions
   localparam int CEF_TYPEC_EV_BIT = 2;
   localparam int CEF_LEGACY_EV_BIT = 1;
   localparam int CEF_MEAS_BIT = 0;
   // Error field positions
   localparam int CEF_PREOV_BIT = 6;
   localparam int CEF_LIMUV_BIT = 5;
   localparam int CEF_LIM_BIT = 4;
   localparam int CEF_OV_BIT = 3;
   // Control field positions
   localparam int CEF_TRIP_SEL_BIT = 0;
   localparam int CEF_TYPEC_EN_BIT = 1;
   localparam int CEF_AUTOCLR_BIT = 2;
   // Reset values
   localparam logic [7:0] CEF_FLAGS_RST = 8'h00;
   localparam logic [7:0] CEF_MASK_RST = 8'h00;
   localparam logic [7:0] CEF_CTRL_RST = 8'h02;
   // Implemented bits of the error register; bit 7 always zero
   localparam logic [7:0] CEF_ERROR_IMPL = 8'h78;
   localparam logic [7:0] CEF_NOTIFY_IMPL = 8'h07;
endpackage : cef_pkg

// [rtl/cef_sync3.sv]
`timescale 1ns/1ns
// Three-stage synchroniser; output changes once stages two and three agree
module cef_sync3 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // Accept a new level only where the last two stages agree
   assign sync_d = (s2_q & s3_q) | (sync_q & (s2_q | s3_q));
   assign sync_out = sync_q;

   // Stage chain; first stage feeds only the second
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         sync_q <= '0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         sync_q <= sync_d;
      end
   end
endmodule : cef_sync3

// [rtl/cef_flags.sv]
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
// Functional notes
// - Type-C attach flag on attach status change
// - Legacy attach flag on change, ignores autoclear
// - Measurement flag on new data, read clears
// - Error register at 0xB, masked interrupt
// - Pre-overvoltage when enabled and unattached
// - Error flag read-clears only once resolved
// - Bit 5 blocked when trip select one
// - Bit 4 blocked when trip select zero
// - Bus overvoltage flag from sense detector
// - Enable zero excludes, one includes flag
module cef_flags
   import cef_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Register port
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // Detector inputs from the analog side
   input wire logic typec_attached_now_in,
   input wire logic legacy_charger_attached_now_in,
   input wire logic meas_done_in,
   input wire logic bus_monitor_ov_in,
   input wire logic limit_uv_in,
   input wire logic current_limit_in,
   input wire logic sense_negative_ov_in,
   // Interrupt
   output logic irq_out
);
   logic [6:0] det_s;
   logic typec_att;
   logic legacy_att;
   logic meas_lvl;
   logic bus_mon_ov;
   logic lim_uv;
   logic cur_lim;
   logic sense_ov;
   logic typec_att_q;
   logic legacy_att_q;
   logic meas_lvl_q;
   logic [7:0] notify_q;
   logic [7:0] notify_d;
   logic [7:0] error_q;
   logic [7:0] error_d;
   logic [7:0] mask_q;
   logic [7:0] nmask_q;
   logic [7:0] ctrl_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic irq_q;
   logic [7:0] notify_set;
   logic [7:0] error_cond;
   logic [7:0] stat_live;
   logic rd_notify;
   logic rd_error;
   logic trip_sel;
   logic typec_en;

   // Pins come from the analog domain, so synchronise them
   cef_sync3 #(
      .WIDTH(7)
   ) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .async_in({typec_attached_now_in, legacy_charger_attached_now_in, meas_done_in,
                 bus_monitor_ov_in, limit_uv_in, current_limit_in, sense_negative_ov_in}),
      .sync_out(det_s)
   );
   assign {typec_att, legacy_att, meas_lvl, bus_mon_ov, lim_uv, cur_lim, sense_ov} = det_s;

   // Control field decode
   assign trip_sel = ctrl_q[CEF_TRIP_SEL_BIT];
   assign typec_en = ctrl_q[CEF_TYPEC_EN_BIT];
   assign rd_notify = rd_in && (addr_in == CEF_NOTIFY_OFF);
   assign rd_error = rd_in && (addr_in == CEF_ERROR_OFF);

   // Notification events: edges of attach status, rising edge of data ready
   always_comb begin
      notify_set = 8'h00;
      notify_set[CEF_TYPEC_EV_BIT] = typec_att ^ typec_att_q;
      notify_set[CEF_LEGACY_EV_BIT] = legacy_att ^ legacy_att_q;
      notify_set[CEF_MEAS_BIT] = meas_lvl & ~meas_lvl_q;
   end

   // Live fault conditions; trip select gates the two limit variants
   always_comb begin
      error_cond = 8'h00;
      error_cond[CEF_PREOV_BIT] = bus_mon_ov & typec_en & ~typec_att;
      error_cond[CEF_LIMUV_BIT] = lim_uv & ~trip_sel;
      error_cond[CEF_LIM_BIT] = cur_lim & trip_sel;
      error_cond[CEF_OV_BIT] = sense_ov;
   end

   // Read clears all notify bits; a same-cycle event still sets.
   // Auto-clear setting has no effect on these bits.
   assign notify_d = ((rd_notify ? 8'h00 : notify_q) | notify_set)
                     & CEF_NOTIFY_IMPL;
   // Error bits survive a read while their cause persists
   assign error_d = ((rd_error ? 8'h00 : error_q) | error_cond)
                    & CEF_ERROR_IMPL;

   assign stat_live = {6'h00, typec_att, legacy_att};

   // Read mux, data valid one cycle after the strobe
   always_comb begin
      rdata_d = 8'h00;
      if (rd_in) begin
         unique case (addr_in)
            CEF_NOTIFY_OFF: rdata_d = notify_q;
            CEF_ERROR_OFF: rdata_d = error_q;
            CEF_MASK_OFF: rdata_d = mask_q;
            CEF_NMASK_OFF: rdata_d = nmask_q;
            CEF_CTRL_OFF: rdata_d = ctrl_q;
            CEF_STAT_OFF: rdata_d = stat_live;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Flags, history and read data
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         typec_att_q <= 1'b0;
         legacy_att_q <= 1'b0;
         meas_lvl_q <= 1'b0;
         notify_q <= CEF_FLAGS_RST;
         error_q <= CEF_FLAGS_RST;
         rdata_q <= 8'h00;
      end else begin
         typec_att_q <= typec_att;
         legacy_att_q <= legacy_att;
         meas_lvl_q <= meas_lvl;
         notify_q <= notify_d;
         error_q <= error_d;
         rdata_q <= rdata_d;
      end
   end

   // Software-written registers; error register itself ignores writes
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         mask_q <= CEF_MASK_RST;
         nmask_q <= CEF_MASK_RST;
         ctrl_q <= CEF_CTRL_RST;
      end else if (wr_in) begin
         if (addr_in == CEF_MASK_OFF) mask_q <= wdata_in & CEF_ERROR_IMPL;
         if (addr_in == CEF_NMASK_OFF) nmask_q <= wdata_in & CEF_NOTIFY_IMPL;
         if (addr_in == CEF_CTRL_OFF) ctrl_q <= wdata_in & 8'h07;
      end
   end

   // Level interrupt, registered so the output is a flop
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(error_d & mask_q) | |(notify_d & nmask_q);
      end
   end

   assign rdata_out = rdata_q;
   assign irq_out = irq_q;

   // Checks
   bit7_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !error_q[7]) else $error("error bit 7 set");
   limuv_block_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      trip_sel && $stable(trip_sel) && !$past(error_q[CEF_LIMUV_BIT]) |->
      !error_q[CEF_LIMUV_BIT]) else $error("bit 5 rose with trip one");
   lim_block_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !trip_sel && $stable(trip_sel) && !$past(error_q[CEF_LIM_BIT]) |->
      !error_q[CEF_LIM_BIT]) else $error("bit 4 rose with trip zero");
   ov_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      sense_ov |=> error_q[CEF_OV_BIT]) else $error("ov not flagged");
   err_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      rd_error && error_cond[CEF_OV_BIT] |=> error_q[CEF_OV_BIT])
      else $error("ov cleared while present");
   err_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      rd_error && error_cond == 8'h00 |=> error_q == 8'h00)
      else $error("resolved flag not cleared");
   typec_ev_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      typec_att != typec_att_q |=> notify_q[CEF_TYPEC_EV_BIT])
      else $error("typec change missed");
   legacy_ev_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !notify_q[CEF_LEGACY_EV_BIT] && $stable(legacy_att) |=>
      !notify_q[CEF_LEGACY_EV_BIT] || $past(legacy_att) != $past(legacy_att_q))
      else $error("legacy flag without change");
   meas_clr_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      rd_notify && !notify_set[CEF_MEAS_BIT] |=> !notify_q[CEF_MEAS_BIT])
      else $error("meas not cleared");
   preov_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      bus_mon_ov && typec_en && !typec_att |=> error_q[CEF_PREOV_BIT])
      else $error("preov missed");
   irq_mask_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (mask_q == 8'h00) && (nmask_q == 8'h00) && $stable(mask_q) && $stable(nmask_q)
      |=> !irq_out) else $error("irq with all masked");

   // Set side of each flag: an event must land one cycle later
   meas_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      notify_set[CEF_MEAS_BIT] |=> notify_q[CEF_MEAS_BIT])
      else $error("meas event missed");

   legacy_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      legacy_att != legacy_att_q |=> notify_q[CEF_LEGACY_EV_BIT])
      else $error("legacy change missed");

   limuv_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      lim_uv && !trip_sel |=> error_q[CEF_LIMUV_BIT])
      else $error("limit undervoltage missed");

   lim_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      cur_lim && trip_sel |=> error_q[CEF_LIM_BIT])
      else $error("current limit missed");

   // Quiet side: no flag appears without its cause
   typec_quiet_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !notify_q[CEF_TYPEC_EV_BIT] && (typec_att == typec_att_q)
      |=> !notify_q[CEF_TYPEC_EV_BIT])
      else $error("typec flag without change");

   preov_block_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (!typec_en || typec_att) && !error_q[CEF_PREOV_BIT] |=> !error_q[CEF_PREOV_BIT])
      else $error("preov while attached or disabled");

   // Error flags stay until a read; a notify read with no new event clears all notify flags
   err_keep_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      error_q[CEF_LIMUV_BIT] && !rd_error |=> error_q[CEF_LIMUV_BIT])
      else $error("error flag lost without read");

   notify_clr_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      rd_notify && (notify_set == 8'h00) |=> notify_q == 8'h00)
      else $error("notify not cleared by read");

   // Read port: data one cycle after the strobe, zero otherwise
   err_rdata_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      rd_error |=> rdata_out == $past(error_q))
      else $error("error read data wrong");

   rdata_idle_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !rd_in |=> rdata_out == 8'h00)
      else $error("read data without strobe");

   // Interrupt follows any enabled error flag
   irq_err_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      |(error_d & mask_q) |=> irq_out)
      else $error("enabled error gave no irq");

   // Unimplemented bits never rise
   err_unused_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (error_q[2:0] == 3'h0) && !mask_q[7])
      else $error("unused error bits set");
endmodule : cef_flags

// [tb/cef_flags_tb_top.sv]
`timescale 1ns/1ns
module cef_flags_tb_top;
   import cef_pkg::*;
   // Design inputs, all defined at time zero
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic tc = 1'b0, lc = 1'b0, meas = 1'b0, bmov = 1'b0, luv = 1'b0, lim = 1'b0, snov = 1'b0;
   logic [7:0] rdata_out;
   logic irq_out;
   logic [7:0] got;
   logic [31:0] seed = 32'h812c_f2c7;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int m_err = 0; // Model of the sticky error flags
   int cond;

   cef_flags cef_flags_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .typec_attached_now_in(tc), .legacy_charger_attached_now_in(lc), .meas_done_in(meas),
      .bus_monitor_ov_in(bmov), .limit_uv_in(luv), .current_limit_in(lim),
      .sense_negative_ov_in(snov), .irq_out(irq_out));

   // 100 MHz clock
   initial begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask : wr

   // Read data exists only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd

   // Inputs pass a synchroniser four flops deep, so allow some margin
   task automatic settle();
      repeat (8) @(posedge clk_sys_in);
   endtask : settle

   task automatic stop_test();
      $display("Errors %0d, checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test

   // Hang guard, well above the length of the sequence
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   initial begin
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      rd(CEF_ERROR_OFF, got);
      chk(got, 8'h00);
      rd(CEF_CTRL_OFF, got);
      chk(got, CEF_CTRL_RST);
      rd(4'h7, got);
      chk(got, 8'h00);
      // Attach then detach on both lines; second half with auto-clear set
      for (int i = 0; i < 4; i++) begin
         if (i == 2) wr(CEF_CTRL_OFF, 8'h06);
         if (i[0]) lc <= ~lc;
         else tc <= ~tc;
         settle();
         rd(CEF_NOTIFY_OFF, got);
         chk(got, i[0] ? 8'h02 : 8'h04);
         rd(CEF_STAT_OFF, got);
         chk(got, {6'h00, tc, lc});
         rd(CEF_NOTIFY_OFF, got);
         chk(got, 8'h00);
      end
      wr(CEF_CTRL_OFF, 8'h02);
      // New data with its interrupt enabled, then cleared by a read
      wr(CEF_NMASK_OFF, 8'h01);
      meas <= 1'b1;
      settle();
      chk(irq_out, 8'h01);
      rd(CEF_NOTIFY_OFF, got);
      chk(got, 8'h01);
      rd(CEF_NOTIFY_OFF, got);
      chk(got, 8'h00);
      @(posedge clk_sys_in);
      #1 chk(irq_out, 8'h00);
      meas <= 1'b0;
      wr(CEF_NMASK_OFF, 8'h00);
      // Random fault levels, trip select and enables; writes to 0xB must not stick
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         // Drop old faults first so a trip select change cannot latch a stale level
         {bmov, luv, lim, snov} <= 4'h0;
         settle();
         wr(CEF_MASK_OFF, seed[15:8]);
         wr(CEF_CTRL_OFF, {7'h01, seed[16]});
         {bmov, luv, lim, snov} <= seed[3:0];
         cond = (seed[3] << 6) | ((seed[2] & !seed[16]) << 5);
         cond = cond | ((seed[1] & seed[16]) << 4) | (seed[0] << 3);
         m_err = m_err | cond;
         wr(CEF_ERROR_OFF, 8'hff);
         settle();
         chk(irq_out, {7'h00, |(m_err[7:0] & seed[15:8])});
         rd(CEF_ERROR_OFF, got);
         chk(got, m_err[7:0]);
         m_err = cond; // Flags whose fault is still present survive the read
      end
      {bmov, luv, lim, snov} <= 4'h0;
      settle();
      rd(CEF_ERROR_OFF, got);
      chk(got, m_err[7:0]);
      rd(CEF_ERROR_OFF, got);
      chk(got, 8'h00);
      @(posedge clk_sys_in);
      #1 chk(irq_out, 8'h00);
      stop_test();
   end
endmodule : cef_flags_tb_top
